//--- acd_regs.svh
`ifndef ACD_REGS_SVH
`define ACD_REGS_SVH

// Division ratios of the two on-chip dividers.
`define ACD_VID_DIV 11'h465
`define ACD_PLL_DIV_DOUBLE 11'h200
`define ACD_PLL_DIV_NORMAL 11'h400

// Reset values of the divider state.
`define ACD_CNT_RST 11'h000
`define ACD_SYNC_RST 3'h0
`define ACD_SEL_RST 2'h0

`endif

//--- acd_pkg.sv
package acd_pkg;

  typedef logic [10:0] acd_cnt_t;

  // Three-stage input sampler: [0] and [1] synchronise, [2] holds the previous value.
  typedef logic [2:0] acd_sync_t;

  typedef struct packed {
    acd_sync_t vid_sync;
    acd_sync_t pll_sync;
    acd_sync_t mclk_sync;
    logic [1:0] sel_sync;
    acd_cnt_t vid_cnt;
    acd_cnt_t pll_cnt;
    logic vid_pulse;
    logic pll_out;
    logic core_tick;
  } acd_state_t;

endpackage : acd_pkg

//--- acd_clock_dividers.sv
`timescale 1ns/10ps
`include "acd_regs.svh"
// Operation
// - Select high: core clock ticks on both input edges, doubling 256x to 512x.
// - Video reference clock is divided by 1125, giving 24 kHz feedback.
// - PLL oscillator clock is divided by 512 in doubler mode.
// - Divided video output is a pulse exactly one clock period wide.
// - Select low: PLL oscillator divider divides by 1024 instead.
module acd_clock_dividers #(
  parameter logic [10:0] VID_DIV = `ACD_VID_DIV,
  parameter logic [10:0] PLL_DIV_DOUBLE = `ACD_PLL_DIV_DOUBLE,
  parameter logic [10:0] PLL_DIV_NORMAL = `ACD_PLL_DIV_NORMAL
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic VIDEO_REF_CLOCK_IN,
  input wire logic PLL_OSC_CLOCK_IN,
  input wire logic MASTER_CLOCK_IN,
  input wire logic CLOCK_MULTIPLY_SEL,
  output logic PLL_FEEDBACK_DIVIDED_OUT,
  output logic VIDEO_REF_DIVIDED_OUT,
  output logic CORE_CLOCK_TICK
);

  acd_pkg::acd_state_t st_q;
  acd_pkg::acd_state_t st_d;

  // Edge detectors read stage 1 and the held copy in stage 2, never stage 0.
  function automatic logic rise(
    input acd_pkg::acd_sync_t s
  );
    rise = s[1] & ~s[2];
  endfunction : rise

  function automatic logic fall(
    input acd_pkg::acd_sync_t s
  );
    fall = ~s[1] & s[2];
  endfunction : fall

  // Next-state pieces, each but dbl from one small function of this module.
  logic dbl;
  logic [10:0] pll_div;
  logic [10:0] pll_half;
  logic [10:0] vid_last;
  logic [10:0] pll_last;
  logic vid_edge;
  logic pll_edge;
  logic mclk_rise;
  logic mclk_fall;
  logic vid_wrap;
  logic [10:0] vid_cnt_next;
  logic [10:0] pll_cnt_next;
  logic pll_level_next;
  logic tick_next;

  // One sampler step: the pin enters stage 0 and the older stages move up.
  function automatic acd_pkg::acd_sync_t sync_step(
    input acd_pkg::acd_sync_t s,
    input logic pin
  );
    sync_step = {s[1:0], pin};
  endfunction : sync_step

  // The strap has no edge detector, so it needs no held copy.
  function automatic logic [1:0] strap_step(
    input logic [1:0] s,
    input logic pin
  );
    strap_step = {s[0], pin};
  endfunction : strap_step

  // Last count value of a divider of the given ratio.
  function automatic acd_pkg::acd_cnt_t last_of(
    input acd_pkg::acd_cnt_t ratio
  );
    last_of = ratio - 11'h001;
  endfunction : last_of

  // Count at which the square wave turns high; an odd ratio loses its spare count.
  function automatic acd_pkg::acd_cnt_t half_of(
    input acd_pkg::acd_cnt_t ratio
  );
    half_of = {1'b0, ratio[10:1]};
  endfunction : half_of

  // A count above the last value also wraps, so a stray count cannot run away.
  function automatic acd_pkg::acd_cnt_t cnt_step(
    input acd_pkg::acd_cnt_t cnt,
    input acd_pkg::acd_cnt_t last
  );
    if (cnt >= last) begin
      cnt_step = `ACD_CNT_RST;
    end else begin
      cnt_step = cnt + 11'h001;
    end
  endfunction : cnt_step

  // The count only moves on a detected input edge.
  function automatic acd_pkg::acd_cnt_t cnt_next(
    input acd_pkg::acd_cnt_t cnt,
    input acd_pkg::acd_cnt_t last,
    input logic edge_seen
  );
    if (edge_seen) begin
      cnt_next = cnt_step(cnt, last);
    end else begin
      cnt_next = cnt;
    end
  endfunction : cnt_next

  // True on the edge that takes the count from its last value back to zero.
  function automatic logic wrap_of(
    input acd_pkg::acd_cnt_t cnt,
    input acd_pkg::acd_cnt_t last,
    input logic edge_seen
  );
    if (edge_seen && (cnt >= last)) begin
      wrap_of = 1'b1;
    end else begin
      wrap_of = 1'b0;
    end
  endfunction : wrap_of

  // Low for the first half of the ratio, high for the second.
  function automatic logic level_of(
    input acd_pkg::acd_cnt_t cnt,
    input acd_pkg::acd_cnt_t half
  );
    if (cnt >= half) begin
      level_of = 1'b1;
    end else begin
      level_of = 1'b0;
    end
  endfunction : level_of

  // Doubler mode takes both input edges, otherwise only rising ones.
  function automatic logic tick_of(
    input logic rise_seen,
    input logic fall_seen,
    input logic double_mode
  );
    if (double_mode) begin
      tick_of = rise_seen | fall_seen;
    end else begin
      tick_of = rise_seen;
    end
  endfunction : tick_of

  // Ratio of the oscillator divider for the strapped mode.
  function automatic acd_pkg::acd_cnt_t pll_ratio(
    input logic double_mode
  );
    if (double_mode) begin
      pll_ratio = PLL_DIV_DOUBLE;
    end else begin
      pll_ratio = PLL_DIV_NORMAL;
    end
  endfunction : pll_ratio

  // The strap is sampled all the time; a mode change in mid-count is not handled.
  assign dbl = st_q.sel_sync[1];
  assign pll_div = pll_ratio(dbl);
  assign pll_half = half_of(pll_div);
  assign vid_last = last_of(VID_DIV);
  assign pll_last = last_of(pll_div);

  // Edges as the samplers see them, two clocks after the pin moves.
  assign vid_edge = rise(st_q.vid_sync);
  assign pll_edge = rise(st_q.pll_sync);
  assign mclk_rise = rise(st_q.mclk_sync);
  assign mclk_fall = fall(st_q.mclk_sync);

  assign vid_wrap = wrap_of(st_q.vid_cnt, vid_last, vid_edge);
  assign vid_cnt_next = cnt_next(st_q.vid_cnt, vid_last, vid_edge);
  assign pll_cnt_next = cnt_next(st_q.pll_cnt, pll_last, pll_edge);
  assign pll_level_next = level_of(pll_cnt_next, pll_half);
  assign tick_next = tick_of(mclk_rise, mclk_fall, dbl);

  // Every state bit is computed here and registered in the process below.
  always_comb begin
    st_d = st_q;
    st_d.vid_sync = sync_step(st_q.vid_sync, VIDEO_REF_CLOCK_IN);
    st_d.pll_sync = sync_step(st_q.pll_sync, PLL_OSC_CLOCK_IN);
    st_d.mclk_sync = sync_step(st_q.mclk_sync, MASTER_CLOCK_IN);
    st_d.sel_sync = strap_step(st_q.sel_sync, CLOCK_MULTIPLY_SEL);
    st_d.core_tick = tick_next;
    st_d.vid_cnt = vid_cnt_next;
    // One clock wide, so the far comparator has to act on edges.
    st_d.vid_pulse = vid_wrap;
    st_d.pll_cnt = pll_cnt_next;
    // The level moves on the same edge as the count that it follows.
    st_d.pll_out = pll_level_next;
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q.vid_sync <= `ACD_SYNC_RST;
      st_q.pll_sync <= `ACD_SYNC_RST;
      st_q.mclk_sync <= `ACD_SYNC_RST;
      st_q.sel_sync <= `ACD_SEL_RST;
      // Counters start from zero, so the first video pulse comes a whole ratio after release and the first divider rise half a ratio.
      st_q.vid_cnt <= `ACD_CNT_RST;
      st_q.pll_cnt <= `ACD_CNT_RST;
      st_q.vid_pulse <= 1'b0;
      st_q.pll_out <= 1'b0;
      st_q.core_tick <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign PLL_FEEDBACK_DIVIDED_OUT = st_q.pll_out;
  assign VIDEO_REF_DIVIDED_OUT = st_q.vid_pulse;
  assign CORE_CLOCK_TICK = st_q.core_tick;

endmodule : acd_clock_dividers

//--- acd_properties.sv
`timescale 1ns/10ps
module acd_props #(parameter logic [10:0] VID_DIV = 11'h465) (
  input wire logic MCLK, RESETN, VIDEO_REF_CLOCK_IN, PLL_OSC_CLOCK_IN, MASTER_CLOCK_IN,
  input wire logic CLOCK_MULTIPLY_SEL, PLL_FEEDBACK_DIVIDED_OUT, VIDEO_REF_DIVIDED_OUT,
  input wire logic CORE_CLOCK_TICK
);
  logic [10:0] vc_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge MCLK or negedge RESETN)
    if (!RESETN) vc_q <= 11'h000;
    else vc_q <= (VIDEO_REF_DIVIDED_OUT ? 11'h000 : vc_q) + 11'($rose(VIDEO_REF_CLOCK_IN));
  sequence s_tick;
    ##[2:4] CORE_CLOCK_TICK;
  endsequence
  a_reset_clear: assert property ($rose(RESETN) |-> !PLL_FEEDBACK_DIVIDED_OUT)
    else $error("divider output set at reset release");
  a_tick_fall: assert property (CLOCK_MULTIPLY_SEL && $fell(MASTER_CLOCK_IN) |-> s_tick)
    else $error("no tick on falling edge");
  a_pulse_one: assert property (VIDEO_REF_DIVIDED_OUT |=> !VIDEO_REF_DIVIDED_OUT)
    else $error("video pulse too wide");
  a_vid_ratio: assert property (VIDEO_REF_DIVIDED_OUT |-> vc_q == VID_DIV)
    else $error("video ratio wrong");
  sequence s_vid_rose3;
    $past(VIDEO_REF_CLOCK_IN, 3) && !$past(VIDEO_REF_CLOCK_IN, 4);
  endsequence
  sequence s_osc_rose3;
    $past(PLL_OSC_CLOCK_IN, 3) && !$past(PLL_OSC_CLOCK_IN, 4);
  endsequence
  a_vid_on_edge: assert property (VIDEO_REF_DIVIDED_OUT |-> s_vid_rose3)
    else $error("video pulse not tied to an input edge");
  a_pll_on_edge: assert property ($changed(PLL_FEEDBACK_DIVIDED_OUT) |-> s_osc_rose3)
    else $error("divider output moved without an input edge");
  a_tick_rise: assert property ($rose(MASTER_CLOCK_IN) |-> ##3 CORE_CLOCK_TICK)
    else $error("no tick on rising edge");
  a_tick_single: assert property (
    !CLOCK_MULTIPLY_SEL && $fell(MASTER_CLOCK_IN) |-> ##3 !CORE_CLOCK_TICK)
    else $error("tick on falling edge in single mode");
endmodule : acd_props
bind acd_clock_dividers acd_props #(.VID_DIV(VID_DIV)) u_props (.*);

//--- acd_osc_model.sv
`timescale 1ns/10ps
module acd_osc_model (
  input wire logic clk, en,
  input wire logic [3:0] half,
  output logic osc
);
  int n = 0;
  // Held low while disabled, so no edge is seen around a reset.
  always @(posedge clk) begin
    #1 osc = en && (n + 1 < half ? osc : !osc);
    n = en && n + 1 < half ? n + 1 : 0;
  end
endmodule : acd_osc_model

//--- tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED %0t %0h %0h", $time, a, b); end end
module tb;
  logic MCLK = 1'b0, RESETN = 1'b0, VIDEO_REF_CLOCK_IN = 1'b0, CLOCK_MULTIPLY_SEL = 1'b1;
  logic PLL_OSC_CLOCK_IN, PLL_FEEDBACK_DIVIDED_OUT, VIDEO_REF_DIVIDED_OUT, CORE_CLOCK_TICK;
  logic en = 1'b0, fb_p;
  logic [3:0] half = 4'h3;
  wire MASTER_CLOCK_IN = PLL_OSC_CLOCK_IN;
  int err_count = 0, tests_run = 0, vr, pr, mr, mf, tk;
  acd_clock_dividers #(.VID_DIV(11'h005), .PLL_DIV_DOUBLE(11'h008), .PLL_DIV_NORMAL(11'h010))
    u_dut (.*);
  acd_osc_model u_osc (.clk(MCLK), .en(en), .half(half), .osc(PLL_OSC_CLOCK_IN));
  initial forever #4 MCLK = !MCLK;
  always @(posedge PLL_OSC_CLOCK_IN) begin pr++; mr++; end
  always @(negedge PLL_OSC_CLOCK_IN) mf++;
  always @(posedge MCLK) if (RESETN) begin
    if (CORE_CLOCK_TICK) tk++;
    if (VIDEO_REF_DIVIDED_OUT) begin `CHK(vr, 5) vr = 0; end
    if (PLL_FEEDBACK_DIVIDED_OUT !== fb_p) begin
      `CHK(pr, CLOCK_MULTIPLY_SEL ? 4 : 8)
      pr = 0;
    end
    fb_p = PLL_FEEDBACK_DIVIDED_OUT;
  end
  initial begin
    void'($urandom(32'h7708));
    for (int p = 0; p < 2; p++) begin
      #1 RESETN = 1'b0;
      CLOCK_MULTIPLY_SEL = p == 0;
      repeat (10) @(posedge MCLK);
      #1 RESETN = 1'b1;
      {vr, pr, fb_p} = '0;
      {mr, mf, tk} = '0;
      en = 1'b1;
      half = 4'($urandom_range(5, 3));
      repeat (200) begin
        repeat ($urandom_range(4, 3)) @(posedge MCLK);
        #1 VIDEO_REF_CLOCK_IN = !VIDEO_REF_CLOCK_IN;
        vr += VIDEO_REF_CLOCK_IN;
      end
      en = 1'b0;
      repeat (10) @(posedge MCLK);
      `CHK(tk, mr + (CLOCK_MULTIPLY_SEL ? mf : 0))
    end
    report_and_stop();
  end
  initial begin
    #100000 err_count++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
endmodule : tb
